//--- logic/hpsc_slot_regs.sv
// slot capability, control and status registers of one downstream port
// assumes config access and slot events all on the port core clock
//
// Operation
// - attention button present, read-only, reset 0
// - power controller present, read-only, reset 0
// - attention indicator present, read-only, reset 0
// - power indicator present, read-only, reset 0
// - surprise removal flag, read-only, reset 0
// - hot-plug capable flag, read-only, reset 0
// - power limit value writable, reset zero
// - power limit scale writable, reset zero
// - limit write sends power limit message
// - physical slot number read-only, reset zero
// - capability defaults loadable by management path
// - button press event enable, reset 0
// - power fault event enable, reset 0
// - presence change event enable, reset 0
// - command completed event enable, reset 0
// - master hot-plug interrupt enable, reset 0
// - attention indicator field, resets to off
// - attention field write sends indicator message
// - power indicator field, resets to off
// - power field write sends indicator message
// - slot power control, 1 means off
// - link active change notification enable
// - sticky flag on link active change
// - sticky flags for four slot events
`timescale 1ns/10ps
module hpsc_slot_regs
    import hpsc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               cfg_wr,
    input  wire logic               cfg_rd,
    input  wire logic [11:0]        cfg_addr,
    input  wire logic [31:0]        cfg_wdata,
    input  wire logic [3:0]         cfg_be,
    output logic      [31:0]        cfg_rdata,
    input  wire logic               cap_load,
    input  wire hpsc_pkg::hpsc_cap_t cap_load_val,
    input  wire hpsc_pkg::hpsc_evt_t slot_evt,
    input  wire logic               dl_active_state,
    output hpsc_pkg::hpsc_msg_t     msg_req,
    output logic                    slot_power_off,
    output logic                    hp_irq
);
    import hpsc_pkg::*;

    hpsc_cap_t   cap;
    logic [15:0] ctl;
    logic        st_abp;
    logic        st_pfd;
    logic        st_pdc;
    logic        st_cc;
    logic        st_dll;
    logic        dl_active;
    logic        cap_hit;
    logic        ctl_hit;
    logic [15:0] ctl_wmask;
    logic [31:0] cap_rd;
    logic [31:0] ctl_rd;
    logic        next_irq;

    assign cap_hit = cfg_wr && (cfg_addr == HPSC_CAP_OFFSET);
    assign ctl_hit = cfg_wr && (cfg_addr == HPSC_CTRL_OFFSET);

    // only implemented bits are writable; reserved ones hold
    assign ctl_wmask = 16'h17fb;

    // capability word: loaded defaults win over software writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap.attn_btn   <= 1'b0;
            cap.pwr_ctrl   <= 1'b0;
            cap.attn_ind   <= 1'b0;
            cap.pwr_ind    <= 1'b0;
            cap.surprise   <= 1'b0;
            cap.hp_capable <= 1'b0;
            cap.pwr_value  <= HPSC_PLV_RST;
            cap.pwr_scale  <= HPSC_PLS_RST;
            cap.slot_num   <= HPSC_PSN_RST;
        end else if (cap_load) begin
            cap <= cap_load_val;
        end else if (cap_hit) begin
            if (cfg_be[0]) begin
                cap.pwr_value[0] <= cfg_wdata[HPSC_CAP_PLV_LO];
            end
            if (cfg_be[1]) begin
                cap.pwr_value[7:1] <= cfg_wdata[HPSC_CAP_PLV_HI:8];
                cap.pwr_scale[0]   <= cfg_wdata[HPSC_CAP_PLS_LO];
            end
            if (cfg_be[2]) begin
                cap.pwr_scale[1] <= cfg_wdata[HPSC_CAP_PLS_HI];
            end
        end
    end

    // control word, software writes only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= 16'h0000;
            ctl[HPSC_CTL_AI_HI:HPSC_CTL_AI_LO] <= HPSC_IND_OFF;
            ctl[HPSC_CTL_PI_HI:HPSC_CTL_PI_LO] <= HPSC_IND_OFF;
        end else if (ctl_hit) begin
            if (cfg_be[0]) begin
                ctl[7:0] <= (cfg_wdata[7:0] & ctl_wmask[7:0])
                          | (ctl[7:0] & ~ctl_wmask[7:0]);
            end
            if (cfg_be[1]) begin
                ctl[15:8] <= (cfg_wdata[15:8] & ctl_wmask[15:8])
                           | (ctl[15:8] & ~ctl_wmask[15:8]);
            end
        end
    end

    // downstream message pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_req <= '0;
        end else begin
            msg_req.pwr_limit <= cap_hit && (cfg_be[0] || cfg_be[1]
                                             || cfg_be[2]);
            msg_req.attn_ind  <= ctl_hit && cfg_be[0];
            // codes stand only with their pulse, zero otherwise
            msg_req.attn_code <= (ctl_hit && cfg_be[0])
                ? cfg_wdata[HPSC_CTL_AI_HI:HPSC_CTL_AI_LO] : 2'h0;
            msg_req.pwr_ind   <= ctl_hit && cfg_be[1];
            msg_req.pwr_code  <= (ctl_hit && cfg_be[1])
                ? cfg_wdata[HPSC_CTL_PI_HI:HPSC_CTL_PI_LO] : 2'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_power_off <= 1'b0;
        end else begin
            slot_power_off <= ctl[HPSC_CTL_PWR];
        end
    end

    // link active mirrors the link state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dl_active <= 1'b0;
        end else begin
            dl_active <= dl_active_state;
        end
    end

    // status flags; a new event beats a same-cycle clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_abp <= 1'b0;
            st_pfd <= 1'b0;
            st_pdc <= 1'b0;
            st_cc  <= 1'b0;
            st_dll <= 1'b0;
        end else begin
            st_abp <= slot_evt.attn_press
                   || (st_abp && !(ctl_hit && cfg_be[2]
                                   && cfg_wdata[HPSC_ST_ABP]));
            st_pfd <= slot_evt.pwr_fault
                   || (st_pfd && !(ctl_hit && cfg_be[2]
                                   && cfg_wdata[HPSC_ST_PFD]));
            st_pdc <= slot_evt.presence_chg
                   || (st_pdc && !(ctl_hit && cfg_be[2]
                                   && cfg_wdata[HPSC_ST_PDC]));
            st_cc  <= slot_evt.cmd_done
                   || (st_cc && !(ctl_hit && cfg_be[2]
                                  && cfg_wdata[HPSC_ST_CC]));
            st_dll <= (dl_active != dl_active_state)
                   || (st_dll && !(ctl_hit && cfg_be[3]
                                   && cfg_wdata[HPSC_ST_DLA]));
        end
    end

    assign next_irq = ctl[HPSC_CTL_HPIE]
                   && ((st_abp && ctl[HPSC_CTL_ABE])
                    || (st_pfd && ctl[HPSC_CTL_PFE])
                    || (st_pdc && ctl[HPSC_CTL_PDE])
                    || (st_cc  && ctl[HPSC_CTL_CCE])
                    || (st_dll && ctl[HPSC_CTL_DLLE]));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hp_irq <= 1'b0;
        end else begin
            hp_irq <= next_irq;
        end
    end

    always_comb begin
        cap_rd = 32'h0000_0000;
        cap_rd[HPSC_CAP_ABP]  = cap.attn_btn;
        cap_rd[HPSC_CAP_PCP]  = cap.pwr_ctrl;
        cap_rd[HPSC_CAP_AIP]  = cap.attn_ind;
        cap_rd[HPSC_CAP_PIP]  = cap.pwr_ind;
        cap_rd[HPSC_CAP_SURP] = cap.surprise;
        cap_rd[HPSC_CAP_HPC]  = cap.hp_capable;
        cap_rd[HPSC_CAP_PLV_HI:HPSC_CAP_PLV_LO] = cap.pwr_value;
        cap_rd[HPSC_CAP_PLS_HI:HPSC_CAP_PLS_LO] = cap.pwr_scale;
        cap_rd[HPSC_CAP_PSN_HI:HPSC_CAP_PSN_LO] = cap.slot_num;
        ctl_rd = {16'h0000, ctl & ctl_wmask};
        ctl_rd[HPSC_ST_ABP] = st_abp;
        ctl_rd[HPSC_ST_PFD] = st_pfd;
        ctl_rd[HPSC_ST_PDC] = st_pdc;
        ctl_rd[HPSC_ST_CC]  = st_cc;
        ctl_rd[HPSC_ST_DLA] = st_dll;
    end

    // registered read data, unmapped reads give zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_rd && cfg_addr == HPSC_CAP_OFFSET) begin
            cfg_rdata <= cap_rd;
        end else if (cfg_rd && cfg_addr == HPSC_CTRL_OFFSET) begin
            cfg_rdata <= ctl_rd;
        end else begin
            cfg_rdata <= 32'h0000_0000;
        end
    end

    // assertions
    power_msg_a: assert property (@(posedge clk) disable iff (!rst_n)
        cap_hit && !cap_load && cfg_be[1] |=> msg_req.pwr_limit)
        else $error("power limit message missing");
    attn_msg_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_hit && cfg_be[0] |=> msg_req.attn_ind
            && msg_req.attn_code == $past(cfg_wdata[7:6]))
        else $error("attention message wrong");
    pind_msg_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_hit && cfg_be[1] |=> msg_req.pwr_ind
            && msg_req.pwr_code == $past(cfg_wdata[9:8]))
        else $error("power indicator message wrong");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctl[HPSC_CTL_HPIE] |=> !hp_irq)
        else $error("interrupt without master enable");
    irq_btn_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctl[HPSC_CTL_HPIE] && ctl[HPSC_CTL_ABE] && st_abp
            |=> hp_irq)
        else $error("button interrupt missing");
    evt_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        slot_evt.pwr_fault |=> st_pfd)
        else $error("power fault flag lost");
    dll_change_a: assert property (@(posedge clk) disable iff (!rst_n)
        dl_active != $past(dl_active) |-> st_dll)
        else $error("link change flag not set");
    power_ctl_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 slot_power_off == $past(ctl[HPSC_CTL_PWR]))
        else $error("power control not followed");
    rsvd_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_rd && cfg_addr == HPSC_CTRL_OFFSET
            |=> cfg_rdata[15:13] == 3'h0 && cfg_rdata[11] == 1'b0)
        else $error("reserved bits read nonzero");

endmodule

//--- logic/hpsc_pkg.sv
// hot-plug slot capability and control register constants and carriers
// assumes a single core clock domain shared with the config access path
package hpsc_pkg;

    localparam logic [11:0] HPSC_CAP_OFFSET  = 12'h0d4;
    localparam logic [11:0] HPSC_CTRL_OFFSET = 12'h0d8;

    // capability word fields
    localparam int HPSC_CAP_ABP   = 0;
    localparam int HPSC_CAP_PCP   = 1;
    localparam int HPSC_CAP_AIP   = 3;
    localparam int HPSC_CAP_PIP   = 4;
    localparam int HPSC_CAP_SURP  = 5;
    localparam int HPSC_CAP_HPC   = 6;
    localparam int HPSC_CAP_PLV_LO = 7;
    localparam int HPSC_CAP_PLV_HI = 14;
    localparam int HPSC_CAP_PLS_LO = 15;
    localparam int HPSC_CAP_PLS_HI = 16;
    localparam int HPSC_CAP_PSN_LO = 19;
    localparam int HPSC_CAP_PSN_HI = 31;

    // control word fields
    localparam int HPSC_CTL_ABE    = 0;
    localparam int HPSC_CTL_PFE    = 1;
    localparam int HPSC_CTL_PDE    = 3;
    localparam int HPSC_CTL_CCE    = 4;
    localparam int HPSC_CTL_HPIE   = 5;
    localparam int HPSC_CTL_AI_LO  = 6;
    localparam int HPSC_CTL_AI_HI  = 7;
    localparam int HPSC_CTL_PI_LO  = 8;
    localparam int HPSC_CTL_PI_HI  = 9;
    localparam int HPSC_CTL_PWR    = 10;
    localparam int HPSC_CTL_DLLE   = 12;

    // status word positions (upper half of the control offset)
    localparam int HPSC_ST_ABP  = 16;
    localparam int HPSC_ST_PFD  = 17;
    localparam int HPSC_ST_PDC  = 19;
    localparam int HPSC_ST_CC   = 20;
    localparam int HPSC_ST_DLA  = 24;

    localparam logic [1:0]  HPSC_IND_OFF   = 2'h3;
    localparam logic [7:0]  HPSC_PLV_RST   = 8'h00;
    localparam logic [1:0]  HPSC_PLS_RST   = 2'h0;
    localparam logic [12:0] HPSC_PSN_RST   = 13'h0000;

    // loadable capability defaults
    typedef struct packed {
        logic [12:0] slot_num;
        logic [1:0]  pwr_scale;
        logic [7:0]  pwr_value;
        logic        hp_capable;
        logic        surprise;
        logic        pwr_ind;
        logic        attn_ind;
        logic        pwr_ctrl;
        logic        attn_btn;
    } hpsc_cap_t;

    // slot events from the hot-plug controller
    typedef struct packed {
        logic attn_press;
        logic pwr_fault;
        logic presence_chg;
        logic cmd_done;
    } hpsc_evt_t;

    // downstream message requests, one-cycle pulses
    typedef struct packed {
        logic       pwr_limit;
        logic       attn_ind;
        logic [1:0] attn_code;
        logic       pwr_ind;
        logic [1:0] pwr_code;
    } hpsc_msg_t;

endpackage

//--- sim/hpsc_slot_model.sv
// stand-in for the downstream slot: event source, link partner, indicators
// assumes the core clock and reset of the slot register block
`timescale 1ns/10ps
module hpsc_slot_model
    import hpsc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire hpsc_pkg::hpsc_evt_t evt_req,
    input  wire logic                link_req,
    input  wire hpsc_pkg::hpsc_msg_t msg_req,
    input  wire logic                slot_power_off,
    output hpsc_pkg::hpsc_evt_t      slot_evt,
    output logic                     dl_active_state,
    output logic [1:0]               attn_shown,
    output logic [1:0]               pwr_shown
);
    // one request cycle gives exactly one event pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_evt <= '0;
            dl_active_state <= 1'b0;
        end else begin
            slot_evt <= evt_req;
            // link only trains while the slot has power
            dl_active_state <= link_req & ~slot_power_off;
        end
    end

    // indicators show the last code received
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            attn_shown <= HPSC_IND_OFF;
            pwr_shown <= HPSC_IND_OFF;
        end else begin
            if (msg_req.attn_ind)
                attn_shown <= msg_req.attn_code;
            if (msg_req.pwr_ind)
                pwr_shown <= msg_req.pwr_code;
        end
    end
endmodule

//--- sim/testbench.sv
// self-checking bench for the slot registers, slot model on the far side
// assumes one 100 MHz core clock, inputs changed at the falling edge
`timescale 1ns/10ps
module testbench;
    import hpsc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n, cfg_wr, cfg_rd, cap_load, link_req;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, ctl_v;
    logic [3:0]  cfg_be;
    logic [1:0]  attn_shown, pwr_shown;
    logic        dl_active_state, slot_power_off, hp_irq;
    hpsc_cap_t   cap_load_val;
    hpsc_evt_t   slot_evt, evt_req;
    hpsc_msg_t   msg_req, last_msg;
    int          errors = 0;
    int          checks_done = 0;
    int          en[4] = '{HPSC_CTL_ABE, HPSC_CTL_PFE,
                           HPSC_CTL_PDE, HPSC_CTL_CCE};
    int          st[4] = '{HPSC_ST_ABP, HPSC_ST_PFD,
                           HPSC_ST_PDC, HPSC_ST_CC};

    always #5 clk = ~clk;

    hpsc_slot_regs i_dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .cap_load(cap_load),
        .cap_load_val(cap_load_val), .slot_evt(slot_evt),
        .dl_active_state(dl_active_state), .msg_req(msg_req),
        .slot_power_off(slot_power_off), .hp_irq(hp_irq));

    hpsc_slot_model i_slot (.clk(clk), .rst_n(rst_n), .evt_req(evt_req),
        .link_req(link_req), .msg_req(msg_req),
        .slot_power_off(slot_power_off), .slot_evt(slot_evt),
        .dl_active_state(dl_active_state), .attn_shown(attn_shown),
        .pwr_shown(pwr_shown));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // message pulse is caught in the cycle after the write edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_be = be;
        @(negedge clk);
        cfg_wr = 1'b0;
        last_msg = msg_req;
        @(negedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        cmp32(cfg_rdata, exp);
        @(negedge clk);
    endtask

    task automatic pulse(input hpsc_evt_t e);
        evt_req = e;
        @(negedge clk);
        evt_req = '0;
        @(negedge clk);
    endtask

    initial begin
        rst_n = 1'b0;
        {cfg_wr, cfg_rd, cap_load, link_req} = '0;
        {cfg_addr, cfg_wdata, cfg_be} = '0;
        cap_load_val = '0;
        evt_req = '0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rd(HPSC_CAP_OFFSET, 32'h0);
        rd(HPSC_CTRL_OFFSET, 32'h3c0);
        cmp32({31'h0, slot_power_off}, 32'h0);
        $display("test reset done");
        wr(HPSC_CAP_OFFSET, 32'hffffffff, 4'hf);
        cmp32({25'h0, last_msg}, 32'h40);
        rd(HPSC_CAP_OFFSET, 32'h0001ff80);
        wr(HPSC_CAP_OFFSET, 32'h0, 4'h1);
        cmp32({25'h0, last_msg}, 32'h40);
        rd(HPSC_CAP_OFFSET, 32'h0001ff00);
        wr(HPSC_CAP_OFFSET, 32'h0, 4'h8);
        cmp32({25'h0, last_msg}, 32'h0);
        // load beats the software write in the same cycle
        cap_load = 1'b1;
        cap_load_val = '1;
        wr(HPSC_CAP_OFFSET, 32'h0, 4'hf);
        cap_load = 1'b0;
        rd(HPSC_CAP_OFFSET, 32'hfff9fffb);
        $display("test capability done");
        for (int c = 1; c < 4; c++) begin
            ctl_v = {22'h0, c[1:0], c[1:0], 6'h0};
            wr(HPSC_CTRL_OFFSET, ctl_v, 4'h3);
            cmp32({25'h0, last_msg},
                  {25'h0, 2'b01, c[1:0], 1'b1, c[1:0]});
            rd(HPSC_CTRL_OFFSET, ctl_v);
            cmp32({30'h0, attn_shown}, {30'h0, c[1:0]});
            cmp32({30'h0, pwr_shown}, {30'h0, c[1:0]});
        end
        wr(HPSC_CTRL_OFFSET, 32'h0000ef44, 4'h3);
        cmp32({25'h0, last_msg}, 32'h2f);
        cmp32({31'h0, slot_power_off}, 32'h1);
        rd(HPSC_CTRL_OFFSET, 32'h740);
        ctl_v = 32'h340;
        wr(HPSC_CTRL_OFFSET, ctl_v, 4'h3);
        cmp32({31'h0, slot_power_off}, 32'h0);
        $display("test control done");
        for (int i = 0; i < 4; i++) begin
            pulse(hpsc_evt_t'(4'b1000 >> i));
            rd(HPSC_CTRL_OFFSET, ctl_v | (32'h1 << st[i]));
            wr(HPSC_CTRL_OFFSET, ctl_v | (32'h1 << en[i]), 4'h3);
            cmp32({31'h0, hp_irq}, 32'h0);
            wr(HPSC_CTRL_OFFSET,
               ctl_v | (32'h21 << en[i] & 32'h3f) | 32'h20, 4'h3);
            cmp32({31'h0, hp_irq}, 32'h1);
            wr(HPSC_CTRL_OFFSET, 32'h1 << st[i], 4'h4);
            cmp32({31'h0, hp_irq}, 32'h0);
            wr(HPSC_CTRL_OFFSET, ctl_v, 4'h3);
        end
        $display("test events done");
        link_req = 1'b1;
        repeat (4) @(negedge clk);
        rd(HPSC_CTRL_OFFSET, ctl_v | 32'h01000000);
        wr(HPSC_CTRL_OFFSET, ctl_v | 32'h1020, 4'h3);
        cmp32({31'h0, hp_irq}, 32'h1);
        wr(HPSC_CTRL_OFFSET, 32'h01000000, 4'h8);
        cmp32({31'h0, hp_irq}, 32'h0);
        link_req = 1'b0;
        repeat (4) @(negedge clk);
        cmp32({31'h0, hp_irq}, 32'h1);
        $display("test link done");
        wr(12'h0d0, 32'hffffffff, 4'hf);
        cmp32({25'h0, last_msg}, 32'h0);
        rd(12'h0d0, 32'h0);
        rd(HPSC_CAP_OFFSET, 32'hfff9fffb);
        $display("test unmapped done");
        give_verdict;
    end

    initial begin
        #50us;
        errors++;
        give_verdict;
    end
endmodule
